// [verilog/sram_host.sv]
/*
  Host controller that runs single read and write cycles on an asynchronous 32-bit
  static memory with byte-lane selects and an error flag.
  Assumes the memory pins are wired to this module directly; data and flag pins arrive
  unsynchronised and pass a two-flop synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - Write strobe stays high through every read cycle.
// - Address is valid before the combined select goes active.
// - Write starts only with select, strobe and a lane select all active.
// - Host never drives data while the memory may drive.
// - Write strobe pulse at least turn-off time plus data setup.
module sram_host #(
  parameter int RD_CYCLES = sram_host_pkg::RD_CYC,
  parameter int WR_CYCLES = sram_host_pkg::WR_CYC,
  parameter int TURN_CYCLES = sram_host_pkg::TURN_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sram_host_pkg::LANES-1:0] req_lanes,
  input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
  output logic rsp_err,
  output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  output logic primary_select_low,
  output logic secondary_select_high,
  output logic out_drive_n,
  output logic write_strobe_n,
  output logic [sram_host_pkg::LANES-1:0] lane_select_n,
  input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_in,
  output logic [sram_host_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_n,
  input wire logic mem_err_in
);
  // Read count is loaded as RD_CYCLES + 1, so a 4-bit counter caps it at 14;
  // shorter strobes than the package minimum would break access or pulse width
  if (RD_CYCLES < sram_host_pkg::RD_CYC || RD_CYCLES > 14 || WR_CYCLES < sram_host_pkg::WR_CYC ||
      WR_CYCLES > 15 || TURN_CYCLES < 1 || TURN_CYCLES > 15)
  begin : g_bad_cycles
    $error("sram_host: cycle counts out of range");
  end

  logic [sram_host_pkg::DATA_W:0] pins_s;
  sync2 #(.WIDTH(sram_host_pkg::DATA_W + 1)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({mem_err_in, mem_data_in}),
    .q(pins_s)
  );

  sram_host_pkg::state_t st_r, st_nxt;
  logic [sram_host_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [sram_host_pkg::LANES-1:0] ln_r, ln_nxt;
  logic req_ready_nxt, rsp_valid_nxt, rsp_err_nxt;
  logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_nxt, mem_data_out_nxt;
  logic [sram_host_pkg::ADDR_W-1:0] mem_addr_nxt;
  logic p_sel_nxt, s_sel_nxt, oe_nxt, we_nxt, doe_nxt;
  logic [sram_host_pkg::LANES-1:0] lsel_nxt;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    ln_nxt = ln_r;
    req_ready_nxt = 1'b0;
    rsp_valid_nxt = 1'b0;
    rsp_err_nxt = rsp_err;
    rsp_rdata_nxt = rsp_rdata;
    mem_addr_nxt = mem_addr;
    mem_data_out_nxt = mem_data_out;
    p_sel_nxt = 1'b1;
    s_sel_nxt = 1'b0;
    oe_nxt = 1'b1;
    we_nxt = 1'b1;
    doe_nxt = 1'b1;
    lsel_nxt = sram_host_pkg::LANES_OFF;
    case (st_r)
      sram_host_pkg::ST_IDLE:
      begin
        req_ready_nxt = 1'b1;
        // A request with no lane would leave the memory deselected, so it is dropped
        if (req_valid && req_ready && req_lanes != '0)
        begin
          req_ready_nxt = 1'b0;
          mem_addr_nxt = req_addr;
          mem_data_out_nxt = req_wdata;
          wr_nxt = req_write;
          ln_nxt = req_lanes;
          st_nxt = sram_host_pkg::ST_SETUP;
        end
      end
      sram_host_pkg::ST_SETUP:
      begin
        // Address stood one cycle before select goes active
        p_sel_nxt = 1'b0;
        s_sel_nxt = 1'b1;
        lsel_nxt = ~ln_r;
        if (wr_r)
        begin
          we_nxt = 1'b0;
          doe_nxt = 1'b0;
          cnt_nxt = sram_host_pkg::CNT_W'(WR_CYCLES - 1);
          st_nxt = sram_host_pkg::ST_WRITE;
        end
        else
        begin
          oe_nxt = 1'b0;
          cnt_nxt = sram_host_pkg::CNT_W'(RD_CYCLES + 1);
          st_nxt = sram_host_pkg::ST_READ;
        end
      end
      sram_host_pkg::ST_READ:
      begin
        p_sel_nxt = 1'b0;
        s_sel_nxt = 1'b1;
        oe_nxt = 1'b0;
        lsel_nxt = ~ln_r;
        // Count covers access time plus the synchroniser delay
        if (cnt_r == '0)
        begin
          for (int i = 0; i < sram_host_pkg::LANES; i++)
            rsp_rdata_nxt[i*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W] =
              ln_r[i] ? pins_s[i*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W] : 8'h00;
          rsp_err_nxt = pins_s[sram_host_pkg::DATA_W];
          rsp_valid_nxt = 1'b1;
          p_sel_nxt = 1'b1;
          s_sel_nxt = 1'b0;
          oe_nxt = 1'b1;
          lsel_nxt = sram_host_pkg::LANES_OFF;
          cnt_nxt = sram_host_pkg::CNT_W'(TURN_CYCLES - 1);
          st_nxt = sram_host_pkg::ST_TURN;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      sram_host_pkg::ST_WRITE:
      begin
        p_sel_nxt = 1'b0;
        s_sel_nxt = 1'b1;
        lsel_nxt = ~ln_r;
        doe_nxt = 1'b0;
        if (cnt_r == '0)
        begin
          // Strobe and select release together; data held one more cycle for hold time
          we_nxt = 1'b1;
          p_sel_nxt = 1'b1;
          s_sel_nxt = 1'b0;
          lsel_nxt = sram_host_pkg::LANES_OFF;
          rsp_valid_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = sram_host_pkg::ST_TURN;
        end
        else
        begin
          we_nxt = 1'b0;
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      sram_host_pkg::ST_TURN:
      begin
        // Idle gap lets the memory drivers float before the next cycle
        if (cnt_r == '0)
        begin
          req_ready_nxt = 1'b1;
          st_nxt = sram_host_pkg::ST_IDLE;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      default:
        st_nxt = sram_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= sram_host_pkg::ST_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      ln_r <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= '0;
      mem_addr <= '0;
      mem_data_out <= '0;
      primary_select_low <= 1'b1;
      secondary_select_high <= 1'b0;
      out_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      lane_select_n <= sram_host_pkg::LANES_OFF;
      mem_data_oe_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      ln_r <= ln_nxt;
      req_ready <= req_ready_nxt;
      rsp_valid <= rsp_valid_nxt;
      rsp_err <= rsp_err_nxt;
      rsp_rdata <= rsp_rdata_nxt;
      mem_addr <= mem_addr_nxt;
      mem_data_out <= mem_data_out_nxt;
      primary_select_low <= p_sel_nxt;
      secondary_select_high <= s_sel_nxt;
      out_drive_n <= oe_nxt;
      write_strobe_n <= we_nxt;
      lane_select_n <= lsel_nxt;
      mem_data_oe_n <= doe_nxt;
    end
  end

  property p_read_no_strobe;
    @(posedge mclk) disable iff (rst) !out_drive_n |-> write_strobe_n;
  endproperty
  a_read_no_strobe: assert property (p_read_no_strobe) else $error("strobe low during read");

  property p_no_contention;
    @(posedge mclk) disable iff (rst) !mem_data_oe_n |-> out_drive_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives while memory may");

  property p_addr_first;
    @(posedge mclk) disable iff (rst)
      $fell(primary_select_low) |-> $stable(mem_addr) && $past(st_r) == sram_host_pkg::ST_SETUP;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("select before address");

  property p_write_start;
    @(posedge mclk) disable iff (rst)
      !write_strobe_n |-> !primary_select_low && secondary_select_high && lane_select_n != sram_host_pkg::LANES_OFF;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write without select");

  property p_pulse_len;
    @(posedge mclk) disable iff (rst)
      // 43 ns floor is six whole cycles at 8 ns, whatever WR_CYCLES says
      $fell(write_strobe_n) |-> !write_strobe_n [*6];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short");

  property p_data_hold;
    @(posedge mclk) disable iff (rst)
      $rose(write_strobe_n) |-> !mem_data_oe_n && $stable(mem_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at write end");

  localparam int RD_ANS = RD_CYCLES + 2;
  property p_read_answer;
    @(posedge mclk) disable iff (rst)
      $fell(out_drive_n) |-> ##[RD_ANS:RD_ANS] rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  property p_sel_comb;
    @(posedge mclk) disable iff (rst) primary_select_low == !secondary_select_high;
  endproperty
  a_sel_comb: assert property (p_sel_comb) else $error("selects disagree");
endmodule // sram_host
`default_nettype wire

// [verilog/sram_host_pkg.sv]
/*
  Constants for the host-side controller of an asynchronous 32-bit static memory with
  byte lanes, dual selects and a single-bit-error flag.
  Assumes a 125 MHz controller clock.
*/
`default_nettype none
package sram_host_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  // Timing figures in picoseconds, as printed for the faster grade
  localparam int T_RC_PS = 45000;
  localparam int T_AA_PS = 45000;
  localparam int T_PWE_PS = 35000;
  localparam int T_HZWE_PS = 18000;
  localparam int T_SD_PS = 25000;
  localparam int T_HZ_PS = 18000;
  // Least times round up
  localparam int RD_CYC = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_MIN_PS = (T_HZWE_PS + T_SD_PS > T_PWE_PS) ? T_HZWE_PS + T_SD_PS : T_PWE_PS;
  localparam int WR_CYC = (WR_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TURN_CYC = (T_HZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam logic [3:0] LANES_OFF = 4'hf;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_TURN = 3'b100
  } state_t;
endpackage
`default_nettype wire

// [verilog/sync2.sv]
/*
  Two-flop synchroniser for pin inputs, parameterised by width.
  Assumes the pins change asynchronously to mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  if (WIDTH < 1)
  begin : g_bad_width
    $error("sync2: WIDTH must be at least 1");
  end
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;
  always_comb
  begin
    meta_nxt = d;
    q_nxt = meta_r;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule // sync2
`default_nettype wire

// [verif/sram_dev_model.sv]
/*
  Behavioural model of the 32-bit static memory with byte lanes and error flag.
  Assumes host pins wired directly; resolves the shared data bus itself.
*/
`timescale 1ns/100ps
`default_nettype none
module sram_dev_model (
  input wire logic [18:0] addr,
  input wire logic primary_select_low,
  input wire logic secondary_select_high,
  input wire logic out_drive_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] lane_select_n,
  input wire logic [31:0] host_data,
  input wire logic host_oe_n,
  input wire logic corrected_err,
  output logic [31:0] bus,
  output logic err_pin,
  output logic clash
);
  logic [31:0] store [0:524287];
  logic [31:0] held_d;
  logic [18:0] held_a;
  logic [3:0] held_l = 4'hf;
  logic sel;
  logic rd_act;
  initial for (int i = 0; i < 524288; i++) store[i] = 32'h0;
  assign sel = !primary_select_low && secondary_select_high && lane_select_n != 4'hf;
  assign rd_act = sel && !out_drive_n && write_strobe_n;
  // Captured in one block so the release edge cannot overwrite it
  always @*
    if (sel && !write_strobe_n)
    begin
      held_a = addr;
      held_l = lane_select_n;
      held_d = host_data;
    end
  always @(negedge (sel && !write_strobe_n))
    for (int i = 0; i < 4; i++)
      if (!held_l[i]) store[held_a][8*i+:8] = held_d[8*i+:8];
  // Floating lanes show the inverse so stale values never pass
  always @*
    for (int i = 0; i < 4; i++)
      if (rd_act && !lane_select_n[i]) bus[8*i+:8] = store[addr][8*i+:8];
      else if (!host_oe_n) bus[8*i+:8] = host_data[8*i+:8];
      else bus[8*i+:8] = ~store[addr][8*i+:8];
  assign err_pin = rd_act ? corrected_err : ~corrected_err;
  assign clash = rd_act && !host_oe_n;
endmodule // sram_dev_model
`default_nettype wire

// [verif/async_sram_ecc_port_test.sv]
/*
  Self-checking bench for the static memory host controller.
  Assumes sram_dev_model on the pins and default timing parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`define chk(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module async_sram_ecc_port_test;
  logic mclk = 0, rst = 1, req_valid = 0, req_write = 0, corrected_err = 0;
  logic [18:0] req_addr = 0;
  logic [3:0] req_lanes = 0;
  logic [31:0] req_wdata = 0;
  logic req_ready, rsp_valid, rsp_err, ps, ss, od_n, ws_n, oe_n, err_pin, clash;
  logic [31:0] rsp_rdata, d_out, bus;
  logic [18:0] m_addr;
  logic [3:0] ls_n;
  logic [31:0] ref_mem [int];
  int seed = 93765, failures = 0, n_tests = 0;
  initial forever #4 mclk = ~mclk;
  sram_host sram_host_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .mem_addr(m_addr),
    .primary_select_low(ps), .secondary_select_high(ss), .out_drive_n(od_n), .write_strobe_n(ws_n),
    .lane_select_n(ls_n), .mem_data_in(bus), .mem_data_out(d_out), .mem_data_oe_n(oe_n),
    .mem_err_in(err_pin));
  sram_dev_model sram_dev_model_inst (.addr(m_addr), .primary_select_low(ps), .secondary_select_high(ss),
    .out_drive_n(od_n), .write_strobe_n(ws_n), .lane_select_n(ls_n), .host_data(d_out), .host_oe_n(oe_n),
    .corrected_err(corrected_err), .bus(bus), .err_pin(err_pin), .clash(clash));
  function automatic logic [31:0] old_word(input logic [18:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : 32'h0;
  endfunction
  task automatic wrap_up;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic op(input logic w, input logic [18:0] a, input logic [3:0] l, input logic [31:0] d,
    input logic e);
    logic [31:0] x;
    int k;
    int lo;
    x = old_word(a);
    corrected_err = e;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_lanes = l;
    req_wdata = d;
    k = 0;
    while (req_ready !== 1'b1 && k < 60)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 60)
    begin
      failures++;
      $display("mismatch at %0t: request never accepted", $time);
      wrap_up();
    end
    @(posedge mclk);
    #1;
    req_valid = 0;
    k = 0;
    lo = 0;
    while (rsp_valid !== 1'b1 && k < 40)
    begin
      @(posedge mclk);
      #1;
      k++;
      if (ws_n === 1'b0) lo++;
      `chk(clash, 1'b0)
    end
    if (k >= 40)
    begin
      failures++;
      $display("mismatch at %0t: no answer", $time);
      wrap_up();
    end
    for (int i = 0; i < 4; i++)
      if (w && l[i]) x[8*i+:8] = d[8*i+:8];
      else if (!w && !l[i]) x[8*i+:8] = 8'h0;
    if (w)
    begin
      ref_mem[a] = x;
      `chk(lo, sram_host_pkg::WR_CYC)
      `chk(lo * sram_host_pkg::CLK_PERIOD_PS >= sram_host_pkg::T_HZWE_PS + sram_host_pkg::T_SD_PS, 1'b1)
    end
    else
    begin
      `chk(lo, 0)
      `chk(rsp_rdata, x)
      `chk(rsp_err, e)
    end
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    rst = 0;
    op(1, 19'h7ffff, 4'hf, 32'h11223344, 0);
    op(0, 19'h7ffff, 4'hf, 0, 0);
    for (int i = 0; i < 4; i++)
      op(1, 19'h5, 4'h1 << i, 32'ha5c3e1f0 + i, 0);
    for (int i = 0; i < 4; i++)
      op(0, 19'h5, 4'h1 << i, 0, 1);
    op(0, 19'h5, 4'hf, 0, 0);
    req_valid = 1;
    req_lanes = 4'h0;
    repeat (8)
    begin
      @(posedge mclk);
      #1;
      `chk(rsp_valid, 1'b0)
      `chk(ps, 1'b1)
    end
    `chk(req_ready, 1'b1)
    req_valid = 0;
    for (int n = 0; n < 200; n++)
    begin
      logic [3:0] l;
      l = $random(seed);
      op($random(seed), $random(seed) & 19'h1f, (l == 4'h0) ? 4'hf : l, $random(seed), $random(seed));
    end
    wrap_up();
  end
endmodule // async_sram_ecc_port_test
`default_nettype wire
